/* ises_pkg.sv */
// Package: register selects, bit positions and masks for the status sets
package ises_pkg;
  // Register select codes for the read port
  localparam logic [2:0] SEL_STD_EVENT = 3'h0;
  localparam logic [2:0] SEL_OPER_EVENT = 3'h1;
  localparam logic [2:0] SEL_MEAS_EVENT = 3'h2;
  localparam logic [2:0] SEL_QUES_EVENT = 3'h3;
  localparam logic [2:0] SEL_OPER_LIVE = 3'h4;
  localparam logic [2:0] SEL_MEAS_LIVE = 3'h5;
  localparam logic [2:0] SEL_QUES_LIVE = 3'h6;
  // Standard event bit positions
  localparam int STD_OPC = 0;
  localparam int STD_QUERY = 2;
  localparam int STD_INTERNAL = 3;
  localparam int STD_EXEC = 4;
  localparam int STD_CMD = 5;
  localparam int STD_LOCAL = 6;
  localparam int STD_POWER = 7;
  // Operation bit positions
  localparam int OPER_CAL = 0;
  localparam int OPER_TRIG = 5;
  localparam int OPER_ARM = 6;
  localparam int OPER_IDLE = 10;
  // Measurement bit positions
  localparam int MEAS_LIMIT0 = 0;
  localparam int MEAS_HIGH_FAIL = 4;
  localparam int MEAS_PASS = 5;
  localparam int MEAS_READY = 6;
  localparam int MEAS_OVER = 7;
  localparam int MEAS_BUF_AVAIL = 8;
  localparam int MEAS_BUF_FULL = 9;
  localparam int MEAS_OUT_EN = 11;
  localparam int MEAS_SRC1 = 13;
  localparam int MEAS_SRC2 = 14;
  // Questionable bit positions
  localparam int QUES_CAL = 8;
  localparam int QUES_WARN = 14;
  // Masks of implemented bits; all other positions read zero
  localparam logic [7:0] STD_USED = 8'hFD;
  localparam logic [15:0] OPER_USED = 16'h0461;
  localparam logic [15:0] MEAS_USED = 16'h6BFF;
  localparam logic [15:0] QUES_USED = 16'h4100;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [3:0] ZERO4 = 4'h0;
  localparam logic [1:0] TWO_READINGS = 2'h2;
endpackage

/* ises_status_regs.sv */
// Status register sets: event latches, live conditions, summaries
`timescale 1ns/1ps
// Summary of operation
// [R1] Four sets: standard, operation, measurement and questionable events.
// [R2] Standard bit 0 sets only on completion query once operations finish.
// [R3] Standard bit 2 sets when host reads an empty output queue.
// [R4] Standard bit 3 sets on an internal operation failure.
// [R5] Standard bit 4 sets on a command execution fault.
// [R6] Standard bit 5 sets on syntax, semantic or embedded trigger errors.
// [R7] Standard bit 6 sets when the local key is pressed.
// [R8] Standard bit 7 sets after a power cycle; bit 1 unused.
// [R9] Operation bit 0 while calibrating; other listed bits unused.
// [R10] Operation bit 5 while waiting in trigger layer for link.
// [R11] Operation bit 6 while waiting in arm layer.
// [R12] Operation bit 10 while idle.
// [R13] Measurement bits 0-3 when limit one to four summaries available.
// [R14] Measurement bit 4 on any high fail, bit 5 all pass.
// [R15] Measurement bit 6 reading ready, bit 7 over range.
// [R16] Measurement bit 8 buffer holds two readings, bit 9 full.
// [R17] Measurement bit 11 while output enable line is low.
// [R18] Measurement bits 13, 14 source compliance; 10, 12, 15 unused.
// [R19] Questionable bit 8 on bad cal constant; cleared by good cal.
// [R20] Questionable bit 14 when a measurement parameter was ignored.
// [R21] Condition registers for three sets, none for standard.
// [R22] Condition registers are read-only and track live conditions.
// [R23] Event bits latch until reset; reading clears the register.
// [R24] Power-up and clear-status zero events; preset leaves them. Power-up here sets standard bit 7; clear-status keeps same-cycle events.
// [R25] Event bits ANDed with enables and ORed into summaries.
// [R26] Unused bit positions read zero and never set.
module ises_status_regs (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Host command side, same clock domain
  input wire logic rd_stb_i,
  input wire logic [2:0] rd_sel_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic clear_status_i,
  input wire logic status_preset_i,
  input wire logic [7:0] std_enable_i,
  input wire logic [15:0] oper_enable_i,
  input wire logic [15:0] meas_enable_i,
  input wire logic [15:0] ques_enable_i,
  // Standard event pulses from command processing
  input wire logic opc_query_i,
  input wire logic ops_pending_i,
  input wire logic empty_queue_read_error_i,
  input wire logic internal_fault_error_i,
  input wire logic execution_fault_i,
  input wire logic syntax_fault_i,
  input wire logic semantic_fault_i,
  input wire logic trigger_in_message_i,
  // Front-panel local key, asynchronous
  input wire logic local_key_request_i,
  // Instrument state levels
  input wire logic calibrating_i,
  input wire logic wait_trigger_link_i,
  input wire logic wait_arm_i,
  input wire logic idle_i,
  input wire logic [3:0] limit_summary_i,
  input wire logic high_limit_fail_i,
  input wire logic all_limits_pass_i,
  input wire logic reading_ready_i,
  input wire logic reading_over_range_i,
  input wire logic [1:0] buffer_count_i,
  input wire logic buffer_full_flag_i,
  input wire logic output_enable_n_i,
  input wire logic source_one_compliance_i,
  input wire logic source_two_compliance_i,
  input wire logic bad_cal_constant_i,
  input wire logic cal_success_i,
  input wire logic parameter_ignored_i,
  // Summary outputs toward the status byte
  output logic std_summary_o,
  output logic oper_summary_o,
  output logic meas_summary_o,
  output logic ques_summary_o
);
  import ises_pkg::*;

  logic [7:0] std_event_reg;
  logic [15:0] oper_event_reg;
  logic [15:0] meas_event_reg;
  logic [15:0] ques_event_reg;
  logic [15:0] oper_live_reg;
  logic [15:0] meas_live_reg;
  logic [15:0] ques_live_reg;
  logic [7:0] std_set;
  logic [15:0] oper_next;
  logic [15:0] meas_next;
  logic [15:0] ques_next;
  logic local_meta_reg;
  logic local_sync_reg;
  logic local_prev_reg;
  logic oe_meta_reg;
  logic oe_sync_reg;
  logic cal_bad_reg;
  logic ready_reg;
  logic [15:0] rd_data_reg;
  logic rd_valid_reg;

  // Latch helper: set beats read-clear so no event is lost
  function automatic logic [15:0] latch16(input logic [15:0] cur,
                                          input logic [15:0] set,
                                          input logic clr,
                                          input logic [15:0] used);
    latch16 = ((clr ? ZERO16 : cur) | set) & used;
  endfunction

  // Two-stage synchronisers for the panel key and the I/O port line
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      local_meta_reg <= 1'b0;
      local_sync_reg <= 1'b0;
      local_prev_reg <= 1'b0;
      oe_meta_reg <= 1'b1;
      oe_sync_reg <= 1'b1;
    end else begin
      local_meta_reg <= local_key_request_i;
      local_sync_reg <= local_meta_reg;
      local_prev_reg <= local_sync_reg;
      oe_meta_reg <= output_enable_n_i;
      oe_sync_reg <= oe_meta_reg;
    end
  end

  // Calibration fault flag survives until a good calibration
  // [R19] bad cal hold
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_bad_reg <= 1'b0;
    end else if (bad_cal_constant_i) begin
      cal_bad_reg <= 1'b1;
    end else if (cal_success_i) begin
      cal_bad_reg <= 1'b0;
    end
  end

  // Reading-ready input delayed one cycle in ready_reg, which feeds no other logic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= reading_ready_i;
    end
  end

  // Standard event sources
  always_comb begin
    std_set = ZERO8;
    // [R2] completion on query
    std_set[STD_OPC] = opc_query_i & ~ops_pending_i;
    // [R3] empty queue read
    std_set[STD_QUERY] = empty_queue_read_error_i;
    // [R4] internal failure
    std_set[STD_INTERNAL] = internal_fault_error_i;
    // [R5] execution fault
    std_set[STD_EXEC] = execution_fault_i;
    // [R6] three command faults
    std_set[STD_CMD] = syntax_fault_i | semantic_fault_i |
                       trigger_in_message_i;
    // [R7] local key edge
    std_set[STD_LOCAL] = local_sync_reg & ~local_prev_reg;
  end

  // Live condition vectors, combinational; only the enable line (two cycles) and cal flag (one cycle) lag the instrument
  // [R21] three condition sets
  always_comb begin
    oper_next = ZERO16;
    // [R9] calibrating
    oper_next[OPER_CAL] = calibrating_i;
    // [R10] trigger layer wait
    oper_next[OPER_TRIG] = wait_trigger_link_i;
    // [R11] arm layer wait
    oper_next[OPER_ARM] = wait_arm_i;
    // [R12] idle state
    oper_next[OPER_IDLE] = idle_i;
    meas_next = ZERO16;
    // [R13] limit summaries
    meas_next[MEAS_LIMIT0 +: 4] = limit_summary_i;
    // [R14] high fail and pass
    meas_next[MEAS_HIGH_FAIL] = high_limit_fail_i;
    meas_next[MEAS_PASS] = all_limits_pass_i;
    // [R15] reading status
    meas_next[MEAS_READY] = reading_ready_i;
    meas_next[MEAS_OVER] = reading_over_range_i;
    // [R16] buffer fill
    meas_next[MEAS_BUF_AVAIL] = (buffer_count_i >= TWO_READINGS) |
                                buffer_full_flag_i;
    meas_next[MEAS_BUF_FULL] = buffer_full_flag_i;
    // [R17] active-low enable line
    meas_next[MEAS_OUT_EN] = ~oe_sync_reg;
    // [R18] source compliance
    meas_next[MEAS_SRC1] = source_one_compliance_i;
    meas_next[MEAS_SRC2] = source_two_compliance_i;
    ques_next = ZERO16;
    ques_next[QUES_CAL] = cal_bad_reg;
    // [R20] ignored parameter
    ques_next[QUES_WARN] = parameter_ignored_i;
  end

  // Condition registers follow the instrument every cycle
  // [R22] continuous tracking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oper_live_reg <= ZERO16;
      meas_live_reg <= ZERO16;
      ques_live_reg <= ZERO16;
    end else begin
      oper_live_reg <= oper_next & OPER_USED;
      meas_live_reg <= meas_next & MEAS_USED;
      ques_live_reg <= ques_next & QUES_USED;
    end
  end

  logic rd_std;
  logic rd_oper;
  logic rd_meas;
  logic rd_ques;
  assign rd_std = rd_stb_i && (rd_sel_i == SEL_STD_EVENT);
  assign rd_oper = rd_stb_i && (rd_sel_i == SEL_OPER_EVENT);
  assign rd_meas = rd_stb_i && (rd_sel_i == SEL_MEAS_EVENT);
  assign rd_ques = rd_stb_i && (rd_sel_i == SEL_QUES_EVENT);

  // Event latches; preset is deliberately not an input here
  // [R23] latch and read-clear
  // [R24] reset and clear-status
  // [R26] unused bits masked
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // [R8] power cycle marks the standard set
      std_event_reg <= 8'h80;
      oper_event_reg <= ZERO16;
      meas_event_reg <= ZERO16;
      ques_event_reg <= ZERO16;
    end else if (clear_status_i) begin
      std_event_reg <= std_set & STD_USED;
      oper_event_reg <= oper_next & OPER_USED;
      meas_event_reg <= meas_next & MEAS_USED;
      ques_event_reg <= ques_next & QUES_USED;
    end else begin
      std_event_reg <= ((rd_std ? ZERO8 : std_event_reg) | std_set) &
                       STD_USED;
      oper_event_reg <= latch16(oper_event_reg, oper_next, rd_oper,
                                OPER_USED);
      meas_event_reg <= latch16(meas_event_reg, meas_next, rd_meas,
                                MEAS_USED);
      ques_event_reg <= latch16(ques_event_reg, ques_next, rd_ques,
                                QUES_USED);
    end
  end

  // Read port: data registered one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= ZERO16;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_stb_i;
      if (rd_stb_i) begin
        case (rd_sel_i)
          SEL_STD_EVENT: rd_data_reg <= {ZERO8, std_event_reg};
          SEL_OPER_EVENT: rd_data_reg <= oper_event_reg;
          SEL_MEAS_EVENT: rd_data_reg <= meas_event_reg;
          SEL_QUES_EVENT: rd_data_reg <= ques_event_reg;
          SEL_OPER_LIVE: rd_data_reg <= oper_live_reg;
          SEL_MEAS_LIVE: rd_data_reg <= meas_live_reg;
          SEL_QUES_LIVE: rd_data_reg <= ques_live_reg;
          default: rd_data_reg <= ZERO16;
        endcase
      end
    end
  end
  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;

  // Summaries are combinational so a read-clear drops them at once
  // [R25] enable and OR
  assign std_summary_o = |(std_event_reg & std_enable_i);
  assign oper_summary_o = |(oper_event_reg & oper_enable_i);
  assign meas_summary_o = |(meas_event_reg & meas_enable_i);
  assign ques_summary_o = |(ques_event_reg & ques_enable_i);

  // Assertions
  sequence s_read_std;
    rd_std && !clear_status_i && (std_set == ZERO8);
  endsequence

  AST_READ_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_read_std |=> std_event_reg == ZERO8) // [R23]
    else $error("standard event not cleared by read");
  AST_LATCH_HOLDS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!rd_oper && !clear_status_i && oper_event_reg[OPER_IDLE])
    |=> oper_event_reg[OPER_IDLE]) // [R23]
    else $error("operation event bit dropped without read");
  AST_CLS_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (clear_status_i && (std_set == ZERO8) && !idle_i && !calibrating_i &&
     !wait_arm_i && !wait_trigger_link_i) |=> oper_event_reg == ZERO16 &&
     std_event_reg == ZERO8) // [R24]
    else $error("clear status left events set");
  AST_IDLE_LIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    idle_i |=> oper_live_reg[OPER_IDLE]) // [R12]
    else $error("idle condition not shown");
  AST_IDLE_GONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !idle_i |=> !oper_live_reg[OPER_IDLE]) // [R22]
    else $error("idle condition did not clear");
  AST_OPC_GATED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!opc_query_i && !std_event_reg[STD_OPC]) |=> !std_event_reg[STD_OPC])
    // [R2]
    else $error("operation complete set without query");
  AST_UNUSED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((meas_event_reg & ~MEAS_USED) == ZERO16) &&
    ((ques_live_reg & ~QUES_USED) == ZERO16) && !std_event_reg[1]) // [R26]
    else $error("unused bit set");
  AST_SUMMARY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    meas_summary_o == |(meas_event_reg & meas_enable_i)) // [R25]
    else $error("measurement summary mismatch");
  AST_CAL_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bad_cal_constant_i ##1 (!cal_success_i)[*2] |=> ques_live_reg[QUES_CAL])
    // [R19]
    else $error("calibration fault not held");
  AST_CMD_FAULT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (syntax_fault_i || semantic_fault_i || trigger_in_message_i)
    |=> std_event_reg[STD_CMD]) // [R6]
    else $error("command fault not latched");
endmodule

/* ises_host_model.sv */
// Host controller model issuing status register reads
`timescale 1ns/1ps
module ises_host_model (
  input wire logic clk_i,
  output logic rd_stb_o,
  output logic [2:0] rd_sel_o,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_valid_i
);
  // Quiet until the bench asks for a read
  initial begin
    rd_stb_o = 1'b0;
    rd_sel_o = 3'h7;
  end
  // Strobe one edge, then wait a bounded time for the one-cycle answer
  task automatic read_reg(input logic [2:0] sel, output logic [15:0] data,
    output logic ok);
    ok = 1'b0;
    data = 16'hFFFF;
    @(negedge clk_i);
    rd_stb_o = 1'b1;
    rd_sel_o = sel;
    @(negedge clk_i);
    rd_stb_o = 1'b0;
    rd_sel_o = ~sel; // A stale select would hide a missed strobe
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rd_valid_i === 1'b1) begin
        ok = 1'b1;
        data = rd_data_i;
      end else @(negedge clk_i);
    end
  endtask
endmodule

/* instrument_status_event_registers_bench.sv */
// Bench: drives status sources, reads every register, compares a model
`timescale 1ns/1ps
module instrument_status_event_registers_bench;
  import ises_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rd_stb, rd_valid, ok, pend, key, cal, trig, arm, idle, hf, pass;
  logic rdy, over, full, oe_n, s1, s2, ign, cf;
  logic [2:0] rd_sel;
  logic [15:0] rd_data, got, oper_en, meas_en, ques_en;
  logic [10:0] pul; // 0-6 standard sources, 7 clear, 8 preset, 9-10 cal
  logic [3:0] lim, sum;
  logic [1:0] cnt;
  logic [7:0] std_en;
  logic [31:0] r;
  int errors = 0, checked = 0, cycles = 0, seed = 32'h9d4a;
  int ev[4], lv[4], en[4];
  int std_bit[7] = '{STD_OPC, STD_QUERY, STD_INTERNAL, STD_EXEC, STD_CMD,
    STD_CMD, STD_CMD};
  // Design under test and the host partner
  ises_status_regs ises_status_regs_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .rd_stb_i(rd_stb), .rd_sel_i(rd_sel), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .clear_status_i(pul[7]),
    .status_preset_i(pul[8]), .std_enable_i(std_en),
    .oper_enable_i(oper_en), .meas_enable_i(meas_en),
    .ques_enable_i(ques_en), .opc_query_i(pul[0]), .ops_pending_i(pend),
    .empty_queue_read_error_i(pul[1]), .internal_fault_error_i(pul[2]),
    .execution_fault_i(pul[3]), .syntax_fault_i(pul[4]),
    .semantic_fault_i(pul[5]), .trigger_in_message_i(pul[6]),
    .local_key_request_i(key), .calibrating_i(cal),
    .wait_trigger_link_i(trig), .wait_arm_i(arm), .idle_i(idle),
    .limit_summary_i(lim), .high_limit_fail_i(hf), .all_limits_pass_i(pass),
    .reading_ready_i(rdy), .reading_over_range_i(over),
    .buffer_count_i(cnt), .buffer_full_flag_i(full),
    .output_enable_n_i(oe_n), .source_one_compliance_i(s1),
    .source_two_compliance_i(s2), .bad_cal_constant_i(pul[9]),
    .cal_success_i(pul[10]), .parameter_ignored_i(ign),
    .std_summary_o(sum[0]), .oper_summary_o(sum[1]),
    .meas_summary_o(sum[2]), .ques_summary_o(sum[3]));
  ises_host_model ises_host_model_i (.clk_i(clk_i), .rd_stb_o(rd_stb),
    .rd_sel_o(rd_sel), .rd_data_i(rd_data), .rd_valid_i(rd_valid));
  // Free-running clock, 5 ns period
  always #2.5 clk_i = ~clk_i;
  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_data(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Wait, then latch the live conditions into the event model
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
    lv[1] = {5'h00, idle, 3'h0, arm, trig, 4'h0, cal};
    lv[2] = {1'b0, s2, s1, 1'b0, ~oe_n, 1'b0, full, (cnt >= 2'h2) | full,
      over, rdy, pass, hf, lim};
    lv[3] = {1'b0, ign, 5'h00, cf, 8'h00};
    for (int i = 1; i < 4; i++) ev[i] |= lv[i];
  endtask
  task automatic pulse(input int i);
    @(negedge clk_i);
    pul[i] = 1'b1;
    @(negedge clk_i);
    pul[i] = 1'b0;
  endtask
  // Read one register; event reads clear, but live levels latch again
  task automatic rd_chk(input int sel);
    ises_host_model_i.read_reg(3'(sel), got, ok);
    cmp_bit(ok, 1'b1);
    if (sel < 4) begin
      cmp_data(got, 16'(ev[sel]));
      ev[sel] = (sel == 0) ? 0 : lv[sel];
    end else if (sel < 7) cmp_data(got, 16'(lv[sel - 3]));
    else cmp_data(got, 16'h0000);
  endtask
  initial begin
    {pul, pend, key, cal, trig, arm, idle, hf, pass, rdy, over} = '0;
    {full, s1, s2, ign, cf, lim, cnt, std_en, oper_en} = '0;
    {meas_en, ques_en} = '0;
    oe_n = 1'b1;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    ev = '{32'h80, 0, 0, 0};
    lv = '{0, 0, 0, 0};
    rd_chk(0);
    rd_chk(0);
    rd_chk(7);
    // Completion query is ignored while operations are pending
    pend = 1'b1;
    pulse(0);
    hold(3);
    rd_chk(0);
    pend = 1'b0;
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      hold(3);
      ev[0] = 1 << std_bit[i];
      rd_chk(0);
    end
    key = 1'b1;
    hold(6);
    ev[0] = 1 << STD_LOCAL;
    rd_chk(0);
    key = 1'b0;
    // Random conditions, enables, cal faults, clear and preset
    for (int it = 0; it < 60; it++) begin
      r = $random(seed);
      {cal, trig, arm, idle, hf, pass, rdy, over, full, oe_n} = r[9:0];
      {s1, s2, ign, lim, cnt, std_en} = r[26:10];
      r = $random(seed);
      {oper_en, meas_en} = r;
      r = $random(seed);
      ques_en = r[15:0];
      if (r[16]) cf = 1'b1;
      else if (r[17]) cf = 1'b0;
      if (r[16] || r[17]) pulse(r[16] ? 9 : 10);
      hold(8);
      if (r[18]) begin
        pulse(7);
        ev[0] = 0;
        for (int i = 1; i < 4; i++) ev[i] = lv[i];
      end else if (r[19]) pulse(8);
      hold(2);
      en = '{int'(std_en), int'(oper_en), int'(meas_en), int'(ques_en)};
      for (int i = 0; i < 4; i++) cmp_bit(sum[i], (ev[i] & en[i]) != 0);
      for (int s = 0; s < 7; s++) rd_chk(s);
    end
    end_sim();
  end
endmodule
